// file: design/overtravel_pkg.sv
// Package: register map, field layout, reset values and modes of the overtravel stop logic
`default_nettype none
package overtravel_pkg;
    localparam logic [3:0]  ADDR_FUNC_SEL   = 4'h0;
    localparam logic [3:0]  ADDR_DIR_SEL    = 4'h1;
    localparam logic [3:0]  ADDR_STOP_METH  = 4'h2;
    localparam logic [3:0]  ADDR_PLUG_LIM   = 4'h3;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;
    localparam logic [3:0]  ADDR_CONTROL    = 4'h5;
    localparam logic [3:0]  ADDR_ERR_CNT    = 4'h6;
    localparam int          FWD_DIS_BIT     = 4;
    localparam int          REV_DIS_BIT     = 8;
    localparam int          DIR_REV_BIT     = 0;
    localparam int          CTRL_LOAD_BIT   = 0;
    localparam int          CTRL_SON_BIT    = 1;
    localparam logic [15:0] FUNC_SEL_RST    = 16'h0000;
    localparam logic [15:0] DIR_SEL_RST     = 16'h0000;
    localparam logic [15:0] STOP_METH_RST   = 16'h0000;
    localparam logic [15:0] PLUG_LIM_RST    = 16'h012c;
    localparam logic [15:0] PLUG_LIM_MAX    = 16'h012c;

    typedef enum logic [2:0] {
        STOP_DB_COAST    = 3'h0,
        STOP_COAST_COAST = 3'h1,
        STOP_DB_PLUG_C   = 3'h2,
        STOP_CO_PLUG_C   = 3'h3,
        STOP_DB_PLUG_Z   = 3'h4,
        STOP_CO_PLUG_Z   = 3'h5
    } stop_method_t;

    typedef enum logic [2:0] {
        ST_RUN       = 3'h0,
        ST_DB        = 3'h1,
        ST_COAST     = 3'h2,
        ST_PLUG      = 3'h3,
        ST_ZERO_CLMP = 3'h4
    } drive_state_t;

    typedef struct packed {
        logic fwd_cmd;
        logic rev_cmd;
    } motion_cmd_t;

    typedef struct packed {
        logic        power_on;
        logic        dyn_brake;
        logic        plug_brake;
        logic        zero_clamp;
        logic [15:0] torque_lim;
        logic        fwd_allow;
        logic        rev_allow;
    } stage_ctl_t;
endpackage
`default_nettype wire

// file: design/overtravel_limit_stop_control.sv
// Overtravel limit detection and stop sequencing for a servo drive
//
// Design decisions made here: the address map and the address-and-strobe port.
`default_nettype none
module overtravel_limit_stop_control #(
    parameter logic [15:0] MOTOR_MAX_TORQUE = 16'h012c,
    parameter int          ERR_W            = 16
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       forward_limit_input_i,
    input  wire logic                       reverse_limit_input_i,
    input  wire logic                       error_clear_input_i,
    input  wire logic                       pos_mode_i,
    input  wire logic                       motor_stopped_i,
    input  wire overtravel_pkg::motion_cmd_t cmd_i,
    input  wire logic                       err_pulse_i,
    input  wire logic [3:0]                 addr_i,
    input  wire logic [15:0]                wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic [15:0]                     rdata_o,
    output overtravel_pkg::stage_ctl_t      stage_o,
    output logic                            overtravel_o
);
    typedef struct packed {
        logic [1:0]                  fwd_sync;
        logic [1:0]                  rev_sync;
        logic [1:0]                  clr_sync;
        logic [15:0]                 func_sel;
        logic [15:0]                 dir_sel;
        logic [15:0]                 stop_meth;
        logic [15:0]                 plug_lim;
        logic                        act_fwd_dis;
        logic                        act_rev_dis;
        logic                        act_dir_rev;
        logic [2:0]                  act_meth;
        logic                        servo_on;
        logic                        servo_on_last;
        overtravel_pkg::drive_state_t state;
        logic [ERR_W-1:0]            err_cnt;
        logic [15:0]                 rdata;
        overtravel_pkg::stage_ctl_t  stage;
        logic                        ot;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic fwd_pin;
    logic rev_pin;
    logic fwd_ot;
    logic rev_ot;
    logic ot_stop;
    logic meth_plug;
    logic meth_zero;
    logic db_at_soff;
    logic [15:0] plug_torque;

    always_comb begin
        // Pin levels only after the second synchroniser stage
        fwd_pin = s_q.fwd_sync[1];
        rev_pin = s_q.rev_sync[1];
        // Clockwise counts as forward in reverse mode: swap which pin guards which command
        if (s_q.act_dir_rev) begin
            fwd_ot = rev_pin & ~s_q.act_rev_dis;
            rev_ot = fwd_pin & ~s_q.act_fwd_dis;
        end else begin
            fwd_ot = fwd_pin & ~s_q.act_fwd_dis;
            rev_ot = rev_pin & ~s_q.act_rev_dis;
        end
        // Stop only when the command pushes into the active limit
        ot_stop = (fwd_ot & cmd_i.fwd_cmd) | (rev_ot & cmd_i.rev_cmd);
        meth_plug = s_q.act_meth >= 3'(overtravel_pkg::STOP_DB_PLUG_C);
        meth_zero = s_q.act_meth >= 3'(overtravel_pkg::STOP_DB_PLUG_Z);
        db_at_soff = (s_q.act_meth == 3'(overtravel_pkg::STOP_DB_COAST))
                   | (s_q.act_meth == 3'(overtravel_pkg::STOP_DB_PLUG_C))
                   | (s_q.act_meth == 3'(overtravel_pkg::STOP_DB_PLUG_Z));
        // Setting above motor rating is clipped, not rejected
        plug_torque = (s_q.plug_lim > MOTOR_MAX_TORQUE) ? MOTOR_MAX_TORQUE
                                                        : s_q.plug_lim;

        s_d = s_q;
        s_d.fwd_sync = {s_q.fwd_sync[0], forward_limit_input_i};
        s_d.rev_sync = {s_q.rev_sync[0], reverse_limit_input_i};
        s_d.clr_sync = {s_q.clr_sync[0], error_clear_input_i};
        s_d.servo_on_last = s_q.servo_on;

        // Register writes
        if (wr_i) begin
            unique case (addr_i)
                overtravel_pkg::ADDR_FUNC_SEL:  s_d.func_sel = wdata_i;
                overtravel_pkg::ADDR_DIR_SEL:   s_d.dir_sel = wdata_i;
                overtravel_pkg::ADDR_STOP_METH: s_d.stop_meth = wdata_i;
                overtravel_pkg::ADDR_PLUG_LIM: begin
                    // Out of range values are ignored
                    if (wdata_i <= overtravel_pkg::PLUG_LIM_MAX) begin
                        s_d.plug_lim = wdata_i;
                    end
                end
                overtravel_pkg::ADDR_CONTROL: begin
                    s_d.servo_on = wdata_i[overtravel_pkg::CTRL_SON_BIT];
                    // Reload stands in for a power cycle; stored values other than the plug limit wait until then
                    if (wdata_i[overtravel_pkg::CTRL_LOAD_BIT]) begin
                        s_d.act_fwd_dis = s_q.func_sel[overtravel_pkg::FWD_DIS_BIT];
                        s_d.act_rev_dis = s_q.func_sel[overtravel_pkg::REV_DIS_BIT];
                        s_d.act_dir_rev = s_q.dir_sel[overtravel_pkg::DIR_REV_BIT];
                        s_d.act_meth = (s_q.stop_meth[3:0] > 4'h5) ? 3'h0
                                                                   : s_q.stop_meth[2:0];
                    end
                end
                default: ;
            endcase
        end

        // Register reads, data one cycle later
        s_d.rdata = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                overtravel_pkg::ADDR_FUNC_SEL:  s_d.rdata = s_q.func_sel;
                overtravel_pkg::ADDR_DIR_SEL:   s_d.rdata = s_q.dir_sel;
                overtravel_pkg::ADDR_STOP_METH: s_d.rdata = s_q.stop_meth;
                overtravel_pkg::ADDR_PLUG_LIM:  s_d.rdata = s_q.plug_lim;
                overtravel_pkg::ADDR_STATUS:
                    s_d.rdata = {8'h00, s_q.state, s_q.ot, fwd_ot, rev_ot,
                                 s_q.clr_sync[1], s_q.servo_on};
                overtravel_pkg::ADDR_CONTROL:   s_d.rdata = {14'h0000, s_q.servo_on, 1'b0};
                overtravel_pkg::ADDR_ERR_CNT:   s_d.rdata = 16'(s_q.err_cnt);
                default:                        s_d.rdata = 16'h0000;
            endcase
        end

        // Error pulses pile up in position mode and only the clear input or reset drops them
        if (s_q.clr_sync[1]) begin
            s_d.err_cnt = '0;
        end else if (pos_mode_i && err_pulse_i) begin
            s_d.err_cnt = s_q.err_cnt + ERR_W'(1);
        end

        // Stop sequencing
        unique case (s_q.state)
            overtravel_pkg::ST_RUN: begin
                if (!s_q.servo_on) begin
                    s_d.state = db_at_soff ? overtravel_pkg::ST_DB : overtravel_pkg::ST_COAST;
                end else if (ot_stop) begin
                    s_d.ot = 1'b1;
                    if (meth_plug) begin
                        s_d.state = overtravel_pkg::ST_PLUG;
                    end else if (s_q.act_meth == 3'(overtravel_pkg::STOP_DB_COAST)) begin
                        s_d.state = overtravel_pkg::ST_DB;
                    end else begin
                        s_d.state = overtravel_pkg::ST_COAST;
                    end
                end else begin
                    s_d.ot = 1'b0;
                end
            end
            overtravel_pkg::ST_DB: begin
                if (motor_stopped_i) begin
                    s_d.state = overtravel_pkg::ST_COAST;
                end
            end
            overtravel_pkg::ST_PLUG: begin
                if (!s_q.servo_on) begin
                    s_d.state = db_at_soff ? overtravel_pkg::ST_DB : overtravel_pkg::ST_COAST;
                end else if (motor_stopped_i) begin
                    s_d.state = meth_zero ? overtravel_pkg::ST_ZERO_CLMP
                                          : overtravel_pkg::ST_COAST;
                end
            end
            overtravel_pkg::ST_COAST, overtravel_pkg::ST_ZERO_CLMP: begin
                if (!s_q.servo_on && s_q.state == overtravel_pkg::ST_ZERO_CLMP) begin
                    s_d.state = overtravel_pkg::ST_COAST;
                end else if (s_q.servo_on && !ot_stop
                             && (!s_q.servo_on_last || s_q.ot)) begin
                    // Leave the stop once commands move away or servo comes back
                    s_d.state = overtravel_pkg::ST_RUN;
                    s_d.ot = 1'b0;
                end
            end
            default: s_d.state = overtravel_pkg::ST_COAST;
        endcase

        // Power stage outputs from the state just entered
        s_d.stage.power_on   = (s_d.state == overtravel_pkg::ST_RUN)
                             | (s_d.state == overtravel_pkg::ST_PLUG)
                             | (s_d.state == overtravel_pkg::ST_ZERO_CLMP);
        s_d.stage.dyn_brake  = s_d.state == overtravel_pkg::ST_DB;
        s_d.stage.plug_brake = s_d.state == overtravel_pkg::ST_PLUG;
        s_d.stage.zero_clamp = s_d.state == overtravel_pkg::ST_ZERO_CLMP;
        s_d.stage.torque_lim = (s_d.state == overtravel_pkg::ST_PLUG) ? plug_torque
                                                                      : MOTOR_MAX_TORQUE;
        // Permission follows the limits only, so the far side can back out during a stop
        s_d.stage.fwd_allow  = ~fwd_ot;
        s_d.stage.rev_allow  = ~rev_ot;

        if (rst_i) begin
            s_d = '0;
            s_d.func_sel   = overtravel_pkg::FUNC_SEL_RST;
            s_d.dir_sel    = overtravel_pkg::DIR_SEL_RST;
            s_d.stop_meth  = overtravel_pkg::STOP_METH_RST;
            s_d.plug_lim   = overtravel_pkg::PLUG_LIM_RST;
            s_d.state      = overtravel_pkg::ST_COAST;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign rdata_o      = s_q.rdata;
    assign stage_o      = s_q.stage;
    assign overtravel_o = s_q.ot;
endmodule
`default_nettype wire

// file: testbench/overtravel_chk.sv
// Checker: port-level assertions for the overtravel stop logic
`default_nettype none
module overtravel_chk #(
    parameter logic [15:0] MOTOR_MAX_TORQUE = 16'h012c
) (
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       forward_limit_input_i,
    input wire logic                       reverse_limit_input_i,
    input wire logic                       motor_stopped_i,
    input wire logic                       rd_i,
    input wire logic [15:0]                rdata_o,
    input wire overtravel_pkg::stage_ctl_t stage_o,
    input wire logic                       overtravel_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence plug_done_s;
        stage_o.plug_brake && motor_stopped_i;
    endsequence
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    plug_cap_a: assert property (stage_o.plug_brake |-> stage_o.torque_lim <= MOTOR_MAX_TORQUE)
        else $error("plug torque above motor rating");
    plug_lim_a: assert property (stage_o.plug_brake |-> stage_o.torque_lim <= 16'h012c)
        else $error("plug torque above range");
    plug_ot_a: assert property (stage_o.plug_brake |-> overtravel_o)
        else $error("plug braking without overtravel");
    clamp_hold_a: assert property (stage_o.zero_clamp |-> stage_o.power_on && !stage_o.dyn_brake)
        else $error("zero clamp without powered loop");
    ot_cause_a: assert property ($rose(overtravel_o) |-> $past(forward_limit_input_i, 2)
        || $past(reverse_limit_input_i, 2) || $past(forward_limit_input_i, 3)
        || $past(reverse_limit_input_i, 3))
        else $error("overtravel without a limit input");
    plug_end_a: assert property (plug_done_s |=> !stage_o.plug_brake)
        else $error("plug braking past standstill");
    clamp_after_a: assert property ($rose(stage_o.zero_clamp) |-> $past(stage_o.plug_brake))
        else $error("zero clamp not after plug braking");
    rst_idle_a: assert property ($fell(rst_i) |-> !overtravel_o && !stage_o.power_on)
        else $error("outputs active after reset");
endmodule
bind overtravel_limit_stop_control overtravel_chk #(.MOTOR_MAX_TORQUE(MOTOR_MAX_TORQUE)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .forward_limit_input_i(forward_limit_input_i),
    .reverse_limit_input_i(reverse_limit_input_i), .motor_stopped_i(motor_stopped_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .stage_o(stage_o), .overtravel_o(overtravel_o));
`default_nettype wire

// file: testbench/motor_model.sv
// Motor and power stage model: reports standstill some cycles after the drive stops
`default_nettype none
module motor_model #(
    parameter int STOP_CYC = 4
) (
    input  wire logic                       clk_i,
    input  wire overtravel_pkg::stage_ctl_t stage_i,
    output logic                            stopped_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // Any brake, coast or clamp slows the shaft; plain run keeps it turning
    always @(posedge clk_i) begin
        if (stage_i.power_on && !stage_i.dyn_brake && !stage_i.plug_brake
            && !stage_i.zero_clamp) cnt <= 0;
        else if (cnt < STOP_CYC) cnt <= cnt + 1;
    end
    assign stopped_o = (cnt == STOP_CYC);
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Testbench: register access and overtravel stop sequences
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                        clk_i = 1'b0, rst_i = 1'b1, lim_f = 1'b0, lim_r = 1'b0;
    logic                        clr = 1'b0, pos_mode = 1'b0, err_pulse = 1'b0;
    logic                        wr = 1'b0, rd = 1'b0, stopped, ot;
    logic [3:0]                  addr = 4'h0;
    logic [15:0]                 wdata = 16'h0000, rdata;
    overtravel_pkg::motion_cmd_t cmd = '0;
    overtravel_pkg::stage_ctl_t  stage;
    int                          error_cnt = 0, tests_run = 0, m;
    initial forever #25 clk_i = ~clk_i;
    // Rating below the top of the plug setting range so the cap can be seen
    overtravel_limit_stop_control #(.MOTOR_MAX_TORQUE(16'h00c8), .ERR_W(16)) dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .forward_limit_input_i(lim_f), .reverse_limit_input_i(lim_r),
        .error_clear_input_i(clr), .pos_mode_i(pos_mode), .motor_stopped_i(stopped),
        .cmd_i(cmd), .err_pulse_i(err_pulse), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .stage_o(stage), .overtravel_o(ot));
    motor_model u_motor (.clk_i(clk_i), .stage_i(stage), .stopped_o(stopped));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        {rd, addr} <= {1'b1, a};
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // Bounded wait: 0 for overtravel, 1 for standstill; a hang ends the run
    task automatic wait_for(input int sel);
        for (int n = 0; n < 60; n++) begin
            @(posedge clk_i);
            #1;
            if ((sel == 0 ? ot : stopped) === 1'b1) return;
        end
        error_cnt++;
        tally_and_finish();
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(overtravel_pkg::ADDR_FUNC_SEL, 16'h0000);
        rd_chk(overtravel_pkg::ADDR_STOP_METH, 16'h0000);
        rd_chk(overtravel_pkg::ADDR_PLUG_LIM, 16'h012c);
        rd_chk(4'hf, 16'h0000);
        wr_reg(overtravel_pkg::ADDR_PLUG_LIM, 16'h012d);
        rd_chk(overtravel_pkg::ADDR_PLUG_LIM, 16'h012c);
        wr_reg(overtravel_pkg::ADDR_PLUG_LIM, 16'h0064);
        rd_chk(overtravel_pkg::ADDR_PLUG_LIM, 16'h0064);
        $display("test registers done");
        // Odd methods run reverse, even forward; mode bit varies too
        for (m = 0; m < 6; m++) begin
            wr_reg(overtravel_pkg::ADDR_STOP_METH, 16'(m));
            wr_reg(overtravel_pkg::ADDR_CONTROL, 16'h0003);
            @(posedge clk_i);
            pos_mode <= m[1];
            cmd <= m[0] ? 2'b01 : 2'b10;
            repeat (6) @(posedge clk_i);
            {lim_f, lim_r} <= m[0] ? 2'b01 : 2'b10;
            wait_for(0);
            chk({stage.fwd_allow, stage.rev_allow}, m[0] ? 2'b10 : 2'b01);
            chk({stage.dyn_brake, stage.plug_brake}, {m == 0, m > 1});
            if (m > 1) chk(stage.torque_lim, 16'h0064);
            wait_for(1);
            repeat (2) @(posedge clk_i);
            #1;
            chk({stage.zero_clamp, stage.power_on}, {2{m > 3}});
            @(posedge clk_i);
            {lim_f, lim_r, cmd} <= 4'h0;
            repeat (6) @(posedge clk_i);
        end
        $display("test stop methods done");
        @(posedge clk_i);
        pos_mode <= 1'b1;
        repeat (3) begin
            @(posedge clk_i);
            err_pulse <= 1'b1;
            @(posedge clk_i);
            err_pulse <= 1'b0;
        end
        rd_chk(overtravel_pkg::ADDR_ERR_CNT, 16'h0003);
        @(posedge clk_i);
        clr <= 1'b1;
        repeat (4) @(posedge clk_i);
        clr <= 1'b0;
        rd_chk(overtravel_pkg::ADDR_ERR_CNT, 16'h0000);
        $display("test error clear done");
        // Disable digits written but not loaded must not act yet
        wr_reg(overtravel_pkg::ADDR_FUNC_SEL, 16'h0110);
        @(posedge clk_i);
        {cmd, lim_f} <= 3'b101;
        wait_for(0);
        chk(stage.fwd_allow, 16'h0000);
        @(posedge clk_i);
        {lim_f, cmd} <= '0;
        repeat (6) @(posedge clk_i);
        wr_reg(overtravel_pkg::ADDR_CONTROL, 16'h0003);
        @(posedge clk_i);
        {cmd, lim_f, lim_r} <= 4'b1011;
        repeat (6) @(posedge clk_i);
        #1;
        chk({ot, stage.fwd_allow, stage.rev_allow}, 3'b011);
        $display("test limit disable done");
        // Reverse mode: the reverse pin now guards forward commands
        @(posedge clk_i);
        lim_f <= 1'b0;
        repeat (3) @(posedge clk_i);
        wr_reg(overtravel_pkg::ADDR_FUNC_SEL, 16'h0000);
        wr_reg(overtravel_pkg::ADDR_DIR_SEL, 16'h0001);
        wr_reg(overtravel_pkg::ADDR_PLUG_LIM, 16'h012c);
        wr_reg(overtravel_pkg::ADDR_CONTROL, 16'h0003);
        wait_for(0);
        chk({stage.fwd_allow, stage.rev_allow}, 2'b01);
        chk(stage.torque_lim, 16'h00c8);
        $display("test reverse mode done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
